// File: rtl/drw_decoder.sv
// Serial DAC command word decoder: link capture, crossing, decode and channel storage
//
// Operation
// R1 - The word holds read/write at bit 28, mask 27:24, kind 23:22, address 21:16, data 15:0.
// R2 - A word with the read/write bit low writes its data to the register the fields select.
// R3 - A word with the read/write bit high starts a readback of the selected register instead.
// R4 - One write reaches every channel whose mask bit is set, so any subset is set at once.
// R5 - Kind 00 sends the write to the system control or channel mode register, never to a DAC.
// R6 - Kind 01 writes the gain coefficient register of the addressed DAC.
// R7 - Kind 10 writes the offset coefficient register of the addressed DAC.
// R8 - Kind 11 writes the input code register of the addressed DAC.
// R9 - Address bits 21:19 pick the register set.
// R10 - Address bits 18:16 pick the DAC level inside the set.
// R11 - Input code and offset registers take all sixteen data bits, bit 15 most significant.
// R12 - The fifteen-bit gain register takes data bits 15:1 and drops bit 0.
// R13 - Only an input code write triggers recomputation of the corrected output code.
// R14 - The host addresses the shared offset DAC with both kind bits high; the decoder sends these words to an input code register.
// R15 - The host uses no address code outside the address table.
// R16 - A write with an all-zero channel mask changes no channel register and has no side effect.
module drw_decoder
(
   // Clocks and reset
   input  wire logic                                          sys_clk_in,
   input  wire logic                                          link_clk_in,
   input  wire logic                                          arst_n_in,
   // Link side command port, link clock
   input  wire logic [drw_pkg::CMD_W-1:0]                     cmd_word_in,
   input  wire logic                                          cmd_valid_in,
   output logic                                               cmd_busy_out,
   // Control and channel mode write, system clock
   output logic                                               ctrl_wr_out,
   output logic      [drw_pkg::NUM_CH-1:0]                    ctrl_mask_out,
   output logic      [drw_pkg::CTRL_W-1:0]                    ctrl_payload_out,
   // Readback request and stored value
   output logic                                               rd_req_out,
   output logic      [drw_pkg::NUM_CH-1:0]                    rd_mask_out,
   output logic      [1:0]                                    rd_kind_out,
   output logic      [drw_pkg::SET_W-1:0]                     rd_set_out,
   output logic      [drw_pkg::LVL_W-1:0]                     rd_level_out,
   output logic      [drw_pkg::DATA_W-1:0]                    rd_data_out,
   // Corrected output code recomputation
   output logic      [drw_pkg::NUM_CH-1:0]                    recalc_out,
   output logic      [drw_pkg::SET_W-1:0]                     recalc_set_out,
   output logic      [drw_pkg::LVL_W-1:0]                     recalc_level_out,
   output logic      [drw_pkg::DATA_W-1:0]                    recalc_code_out,
   output logic      [drw_pkg::NUM_CH-1:0][drw_pkg::GAIN_W-1:0] recalc_gain_out,
   output logic      [drw_pkg::NUM_CH-1:0][drw_pkg::DATA_W-1:0] recalc_offs_out
);
   import drw_pkg::*;

   // ****************************************
   // Link domain: capture and request toggle
   // ****************************************
   logic [CMD_W-1:0] cmd_hold;
   logic             req_tgl;
   logic             ack_s1;
   logic             ack_s2;
   logic             accept;
   logic             next_busy;
   logic             ack_tgl;

   // A new word is refused while the previous one is still crossing
   assign accept    = cmd_valid_in && !cmd_busy_out;
   assign next_busy = accept || (cmd_busy_out && (ack_s2 != req_tgl));

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd_hold <= '0;
      end else if (accept) begin
         cmd_hold <= cmd_word_in;
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req_tgl <= 1'b0;
      end else if (accept) begin
         req_tgl <= ~req_tgl;
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd_busy_out <= 1'b0;
      end else begin
         cmd_busy_out <= next_busy;
      end
   end

   // ****************************************
   // System domain: request synchroniser
   // ****************************************
   logic req_s1;
   logic req_s2;
   logic new_cmd;

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req_s1  <= 1'b0;
         req_s2  <= 1'b0;
         ack_tgl <= 1'b0;
      end else begin
         req_s1  <= req_tgl;
         req_s2  <= req_s1;
         ack_tgl <= req_s2;
      end
   end

   // The held word stays still until the acknowledge returns, so it is safe to read here
   assign new_cmd = req_s2 ^ ack_tgl;

   // ****************************************
   // Field decode
   // ****************************************
   logic                 is_read;
   logic [NUM_CH-1:0]    ch_mask;
   drw_kind_e            kind;
   logic [SET_W-1:0]     set_sel;
   logic [LVL_W-1:0]     lvl_sel;
   logic [IDX_W-1:0]     idx;
   logic [DATA_W-1:0]    data;
   logic                 dac_write;

   assign is_read   = cmd_hold[RW_BIT];                      // R1
   assign ch_mask   = cmd_hold[MASK_HI:MASK_LO];             // R1
   assign kind      = drw_kind_e'(cmd_hold[KIND_HI:KIND_LO]); // R1
   assign set_sel   = cmd_hold[SET_HI:SET_LO];               // R9
   assign lvl_sel   = cmd_hold[LVL_HI:LVL_LO];               // R10
   assign idx       = {set_sel, lvl_sel};                    // R9 R10
   assign data      = cmd_hold[DATA_HI:DATA_LO];             // R1
   assign dac_write = new_cmd && !is_read && (kind != DRW_KIND_CTRL); // R2 R5

   // ****************************************
   // Channel storage
   // ****************************************
   logic [NUM_CH-1:0][DATA_W-1:0] ch_input;
   logic [NUM_CH-1:0][DATA_W-1:0] ch_offs;
   logic [NUM_CH-1:0][GAIN_W-1:0] ch_gain;

   for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      // An empty mask enables no bank at all
      drw_chan_regs u_regs (
         .sys_clk_in     (sys_clk_in),
         .arst_n_in      (arst_n_in),
         .wr_en_in       (dac_write && ch_mask[c]), // R4 R16
         .wr_kind_in     (kind),
         .idx_in         (idx),
         .wr_data_in     (data),
         .input_code_out (ch_input[c]),
         .offs_coeff_out (ch_offs[c]),
         .gain_coeff_out (ch_gain[c])
      );
   end

   // ****************************************
   // Readback value of the lowest selected channel
   // ****************************************
   logic [DATA_W-1:0] next_rd_data;

   always_comb begin
      next_rd_data = ZERO_DATA;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (ch_mask[c]) begin
            case (kind)
               DRW_KIND_INPUT: next_rd_data = ch_input[c];
               DRW_KIND_OFFS:  next_rd_data = ch_offs[c];
               DRW_KIND_GAIN:  next_rd_data = {ch_gain[c], 1'b0};
               default:        next_rd_data = ZERO_DATA;
            endcase
         end
      end
   end

   // ****************************************
   // Control register write path
   // ****************************************
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_wr_out <= 1'b0;
      end else begin
         ctrl_wr_out <= new_cmd && !is_read && (kind == DRW_KIND_CTRL)
                        && (ch_mask != '0); // R5 R16
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_mask_out    <= '0;
         ctrl_payload_out <= '0;
      end else if (new_cmd && !is_read && (kind == DRW_KIND_CTRL) && (ch_mask != '0)) begin
         ctrl_mask_out    <= ch_mask;
         ctrl_payload_out <= cmd_hold[CTRL_HI:DATA_LO]; // R5
      end
   end

   // ****************************************
   // Readback request
   // ****************************************
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_req_out <= 1'b0;
      end else begin
         rd_req_out <= new_cmd && is_read; // R3
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_mask_out  <= '0;
         rd_kind_out  <= '0;
         rd_set_out   <= '0;
         rd_level_out <= '0;
         rd_data_out  <= '0;
      end else if (new_cmd && is_read) begin // R3
         rd_mask_out  <= ch_mask;
         rd_kind_out  <= kind;
         rd_set_out   <= set_sel;
         rd_level_out <= lvl_sel;
         rd_data_out  <= next_rd_data;
      end
   end

   // ****************************************
   // Recompute trigger
   // ****************************************
   logic input_write;

   // Coefficient writes alone leave the corrected code as it was
   assign input_write = dac_write && (kind == DRW_KIND_INPUT); // R13

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         recalc_out <= '0;
      end else begin
         recalc_out <= input_write ? ch_mask : '0; // R13 R4 R16
      end
   end

   // Coefficients are sampled before the write lands; an input write never changes them
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         recalc_set_out   <= '0;
         recalc_level_out <= '0;
         recalc_code_out  <= '0;
         recalc_gain_out  <= '0;
         recalc_offs_out  <= '0;
      end else if (input_write && (ch_mask != '0)) begin // R13
         recalc_set_out   <= set_sel;
         recalc_level_out <= lvl_sel;
         recalc_code_out  <= data;
         recalc_gain_out  <= ch_gain;
         recalc_offs_out  <= ch_offs;
      end
   end

endmodule : drw_decoder

// File: shared/drw_pkg.sv
// Command word layout, register-kind codes and reset values for the DAC write decoder
package drw_pkg;

   // ****************************************
   // Command word fields
   // ****************************************
   localparam int CMD_W    = 29;
   localparam int RW_BIT   = 28;
   localparam int MASK_HI  = 27;
   localparam int MASK_LO  = 24;
   localparam int KIND_HI  = 23;
   localparam int KIND_LO  = 22;
   localparam int SET_HI   = 21;
   localparam int SET_LO   = 19;
   localparam int LVL_HI   = 18;
   localparam int LVL_LO   = 16;
   localparam int DATA_HI  = 15;
   localparam int DATA_LO  = 0;
   localparam int CTRL_HI  = 21;
   localparam int CTRL_W   = 22;

   // ****************************************
   // Widths
   // ****************************************
   localparam int NUM_CH   = 4;
   localparam int SET_W    = 3;
   localparam int LVL_W    = 3;
   localparam int IDX_W    = 6;
   localparam int ENTRIES  = 64;
   localparam int DATA_W   = 16;
   localparam int GAIN_W   = 15;
   localparam int GAIN_LSB = 1;

   // ****************************************
   // Register kinds and reset values
   // ****************************************
   typedef enum logic [1:0] {
      DRW_KIND_CTRL  = 2'h0,
      DRW_KIND_GAIN  = 2'h1,
      DRW_KIND_OFFS  = 2'h2,
      DRW_KIND_INPUT = 2'h3
   } drw_kind_e;

   localparam logic [DATA_W-1:0] INPUT_RST = 16'h0000;
   localparam logic [DATA_W-1:0] OFFS_RST  = 16'h0000;
   localparam logic [GAIN_W-1:0] GAIN_RST  = 15'h0000;
   localparam logic [DATA_W-1:0] ZERO_DATA = 16'h0000;

endpackage : drw_pkg

// File: rtl/drw_chan_regs.sv
// Gain, offset and input code storage of one measurement channel
module drw_chan_regs
#(
   parameter int NUM_ENTRIES = drw_pkg::ENTRIES,
   parameter int ADDR_W      = drw_pkg::IDX_W
) (
   // Clock and reset
   input  wire logic                       sys_clk_in,
   input  wire logic                       arst_n_in,
   // Write port
   input  wire logic                       wr_en_in,
   input  wire drw_pkg::drw_kind_e         wr_kind_in,
   input  wire logic [ADDR_W-1:0]          idx_in,
   input  wire logic [drw_pkg::DATA_W-1:0] wr_data_in,
   // Read port, same index
   output logic      [drw_pkg::DATA_W-1:0] input_code_out,
   output logic      [drw_pkg::DATA_W-1:0] offs_coeff_out,
   output logic      [drw_pkg::GAIN_W-1:0] gain_coeff_out
);
   import drw_pkg::*;

   logic [DATA_W-1:0] dac_input_code   [NUM_ENTRIES];
   logic [DATA_W-1:0] dac_offset_coeff [NUM_ENTRIES];
   logic [GAIN_W-1:0] dac_gain_coeff   [NUM_ENTRIES];

   for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_entry
      logic hit;
      assign hit = wr_en_in && (idx_in == ADDR_W'(e));

      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            dac_input_code[e] <= INPUT_RST;
         end else if (hit && wr_kind_in == DRW_KIND_INPUT) begin // R8
            dac_input_code[e] <= wr_data_in;                     // R11
         end
      end

      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            dac_offset_coeff[e] <= OFFS_RST;
         end else if (hit && wr_kind_in == DRW_KIND_OFFS) begin  // R7
            dac_offset_coeff[e] <= wr_data_in;                   // R11
         end
      end

      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            dac_gain_coeff[e] <= GAIN_RST;
         end else if (hit && wr_kind_in == DRW_KIND_GAIN) begin  // R6
            // Data bit 0 has no home in the gain register
            dac_gain_coeff[e] <= wr_data_in[DATA_HI:GAIN_LSB];   // R12
         end
      end
   end

   assign input_code_out = dac_input_code[idx_in];
   assign offs_coeff_out = dac_offset_coeff[idx_in];
   assign gain_coeff_out = dac_gain_coeff[idx_in];

endmodule : drw_chan_regs

// File: testbench/drw_decoder_monitor.sv
// Port assertions of the DAC command word decoder
module drw_decoder_monitor
(
   // Clocks and reset
   input  wire logic                       sys_clk_in,
   input  wire logic                       link_clk_in,
   input  wire logic                       arst_n_in,
   // Observed ports
   input  wire logic                       cmd_valid_in,
   input  wire logic                       cmd_busy_out,
   input  wire logic                       ctrl_wr_out,
   input  wire logic [drw_pkg::NUM_CH-1:0] ctrl_mask_out,
   input  wire logic [drw_pkg::CTRL_W-1:0] ctrl_payload_out,
   input  wire logic                       rd_req_out,
   input  wire logic [drw_pkg::NUM_CH-1:0] rd_mask_out,
   input  wire logic [1:0]                 rd_kind_out,
   input  wire logic [drw_pkg::DATA_W-1:0] rd_data_out,
   input  wire logic [drw_pkg::NUM_CH-1:0] recalc_out,
   input  wire logic [drw_pkg::DATA_W-1:0] recalc_code_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import drw_pkg::*;
   // ****************************************
   // System clock side
   // ****************************************
   ctrl_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      ctrl_wr_out |=> !ctrl_wr_out) else $error("control write pulse too long");
   ctrl_mask_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      ctrl_wr_out |-> ctrl_mask_out != 4'h0) else $error("control write with empty mask");
   ctrl_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !ctrl_wr_out |-> $stable(ctrl_payload_out)) else $error("control payload moved");
   kind_excl_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !(ctrl_wr_out && recalc_out != 4'h0)) else $error("control and input write together");
   recalc_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      recalc_out != 4'h0 |=> recalc_out == 4'h0) else $error("recalc pulse too long");
   recalc_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      recalc_out == 4'h0 |-> $stable(recalc_code_out)) else $error("recalc code moved");
   rd_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      rd_req_out |=> !rd_req_out [*3]) else $error("readback pulse too long");
   rd_hold_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      !rd_req_out |-> $stable(rd_data_out)) else $error("readback data moved");
   rd_zero_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      rd_req_out && (rd_mask_out == 4'h0 || rd_kind_out == 2'h0) |-> rd_data_out == 16'h0000)
      else $error("readback of no DAC not zero");
   gain_lsb_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
      rd_req_out && rd_kind_out == 2'h1 |-> !rd_data_out[0]) else $error("gain lsb set");
   // ****************************************
   // Link clock side, then system clock covers
   // ****************************************
   busy_rise_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      cmd_valid_in && !cmd_busy_out |=> cmd_busy_out) else $error("word not taken");
   busy_end_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      $rose(cmd_busy_out) |-> ##[1:40] !cmd_busy_out) else $error("busy never ends");
   cover property (@(posedge sys_clk_in) recalc_out == 4'h5);
   cover property (@(posedge sys_clk_in) ctrl_wr_out);
   cover property (@(posedge sys_clk_in) rd_req_out && rd_kind_out == 2'h1);
endmodule : drw_decoder_monitor

bind drw_decoder drw_decoder_monitor i_mon (
   .sys_clk_in, .link_clk_in, .arst_n_in, .cmd_valid_in, .cmd_busy_out, .ctrl_wr_out,
   .ctrl_mask_out, .ctrl_payload_out, .rd_req_out, .rd_mask_out, .rd_kind_out,
   .rd_data_out, .recalc_out, .recalc_code_out
);

// File: testbench/drw_host_model.sv
// Host controller model offering command words on the link port
module drw_host_model
(
   // Link port
   input  wire logic                      link_clk_in,
   input  wire logic                      busy_in,
   output logic      [drw_pkg::CMD_W-1:0] cmd_word_out,
   output logic                           cmd_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import drw_pkg::*;
   logic timed_out = 1'b0;
   initial begin
      cmd_valid_out = 1'b0;
      cmd_word_out  = '0;
   end
   // Callers pick table addresses only, offset DAC with kind 11
   task automatic send(input logic [drw_pkg::CMD_W-1:0] word);
      int n;
      n = 0;
      @(negedge link_clk_in);
      while (busy_in === 1'b1 && n < 100) begin
         @(negedge link_clk_in);
         n++;
      end
      timed_out = (n >= 100);
      cmd_word_out  = word;
      cmd_valid_out = 1'b1;
      @(negedge link_clk_in);
      cmd_valid_out = 1'b0;
      // Released word shows the inverse, not the last value
      cmd_word_out  = ~word;
   endtask : send
endmodule : drw_host_model

// File: testbench/tb.sv
// Self-checking bench of the DAC command word decoder
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import drw_pkg::*;
   logic                          sys_clk_in = 1'b0;
   logic                          link_clk_in = 1'b0;
   logic                          arst_n_in = 1'b0;
   logic [CMD_W-1:0]              cmd_word_in;
   logic                          cmd_valid_in, cmd_busy_out, ctrl_wr_out, rd_req_out;
   logic [NUM_CH-1:0]             ctrl_mask_out, rd_mask_out, recalc_out, rc_mask;
   logic [CTRL_W-1:0]             ctrl_payload_out;
   logic [1:0]                    rd_kind_out;
   logic [SET_W-1:0]              rd_set_out, rd_level_out, recalc_set_out, recalc_level_out;
   logic [DATA_W-1:0]             rd_data_out, recalc_code_out;
   logic [NUM_CH-1:0][GAIN_W-1:0] recalc_gain_out;
   logic [NUM_CH-1:0][DATA_W-1:0] recalc_offs_out;
   int                            n_mismatch = 0, comparisons = 0, n_ctrl = 0, n_rd = 0, n_rc = 0;

   always #4 sys_clk_in = ~sys_clk_in;
   initial begin
      #1.3;
      forever #3 link_clk_in = ~link_clk_in;
   end

   drw_decoder i_dut (
      .sys_clk_in, .link_clk_in, .arst_n_in, .cmd_word_in, .cmd_valid_in, .cmd_busy_out,
      .ctrl_wr_out, .ctrl_mask_out, .ctrl_payload_out, .rd_req_out, .rd_mask_out,
      .rd_kind_out, .rd_set_out, .rd_level_out, .rd_data_out, .recalc_out, .recalc_set_out,
      .recalc_level_out, .recalc_code_out, .recalc_gain_out, .recalc_offs_out
   );
   drw_host_model i_host (
      .link_clk_in, .busy_in(cmd_busy_out), .cmd_word_out(cmd_word_in),
      .cmd_valid_out(cmd_valid_in)
   );

   // ****************************************
   // Pulse counting and tasks
   // ****************************************
   always @(posedge sys_clk_in) begin
      if (ctrl_wr_out === 1'b1) n_ctrl++;
      if (rd_req_out === 1'b1) n_rd++;
      if (recalc_out !== 4'h0) begin
         n_rc++;
         rc_mask = recalc_out;
      end
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // Waits for the word to cross both ways so the sys side outputs have settled
   task automatic op(input logic rd, input logic [3:0] mask, input drw_kind_e kind,
                     input logic [5:0] addr, input logic [15:0] data);
      int n;
      n = 0;
      i_host.send({rd, mask, kind, addr, data});
      repeat (2) @(negedge link_clk_in);
      while (cmd_busy_out === 1'b1 && n < 100) begin
         @(negedge link_clk_in);
         n++;
      end
      if (i_host.timed_out || n >= 100) begin
         n_mismatch++;
         finish_test();
      end
      repeat (2) @(negedge sys_clk_in);
   endtask : op

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(negedge sys_clk_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      op(1'b0, 4'h5, DRW_KIND_INPUT, 6'h08, 16'hA5A5);
      chk("recalc mask", 32'h5, rc_mask);
      chk("recalc code", 32'hA5A5, recalc_code_out);
      chk("recalc addr", 32'h08, {recalc_set_out, recalc_level_out});
      $display("test input write done");
      op(1'b0, 4'h2, DRW_KIND_GAIN, 6'h08, 16'h1235);
      op(1'b0, 4'hF, DRW_KIND_OFFS, 6'h08, 16'h8001);
      chk("recalc count", 32'd1, n_rc);
      op(1'b1, 4'h2, DRW_KIND_GAIN, 6'h08, 16'h0000);
      chk("gain readback", 32'h1234, rd_data_out);
      op(1'b1, 4'h8, DRW_KIND_OFFS, 6'h08, 16'h0000);
      chk("offset readback", 32'h8001, rd_data_out);
      chk("read fields", 32'h0888, {rd_mask_out, rd_kind_out, rd_set_out, rd_level_out});
      op(1'b0, 4'h2, DRW_KIND_INPUT, 6'h08, 16'h0F0F);
      chk("recalc gain", 32'h091A, recalc_gain_out[1]);
      chk("recalc offset", 32'h8001, recalc_offs_out[1]);
      $display("test coefficients done");
      op(1'b0, 4'h1, DRW_KIND_INPUT, 6'h2D, 16'h1357);
      op(1'b1, 4'h1, DRW_KIND_INPUT, 6'h08, 16'h0000);
      chk("input readback", 32'hA5A5, rd_data_out);
      op(1'b1, 4'h1, DRW_KIND_INPUT, 6'h2D, 16'h0000);
      chk("set level readback", 32'h1357, rd_data_out);
      op(1'b1, 4'h4, DRW_KIND_GAIN, 6'h29, 16'h0000);
      chk("reset value", 32'h0000, rd_data_out);
      $display("test addressing done");
      op(1'b0, 4'h3, DRW_KIND_CTRL, 6'h15, 16'hC3C3);
      chk("ctrl payload", 32'h15C3C3, ctrl_payload_out);
      chk("ctrl mask", 32'h3, ctrl_mask_out);
      op(1'b0, 4'h0, DRW_KIND_INPUT, 6'h08, 16'hFFFF);
      op(1'b0, 4'h0, DRW_KIND_CTRL, 6'h08, 16'hFFFF);
      chk("ctrl count", 32'd1, n_ctrl);
      chk("recalc total", 32'd3, n_rc);
      op(1'b1, 4'h1, DRW_KIND_INPUT, 6'h08, 16'h0000);
      chk("input kept", 32'hA5A5, rd_data_out);
      op(1'b1, 4'h0, DRW_KIND_INPUT, 6'h08, 16'h0000);
      chk("empty mask readback", 32'h0000, rd_data_out);
      chk("read count", 32'd7, n_rd);
      $display("test control and empty mask done");
      finish_test();
   end
endmodule : tb
